// ### verilog/cbpx_pkg.sv
package cbpx_pkg;

    // Bus cycle states of the sequencer
    typedef enum logic [2:0] {
        CBPX_IDLE,
        CBPX_STATUS,
        CBPX_COMMAND,
        CBPX_HOLD
    } cbpx_state_e;

    // Processor cycle phase encoding on the phase indicator
    localparam logic CBPX_PHASE_ONE = 1'b0;
    localparam logic CBPX_PHASE_TWO = 1'b1;

    // Coprocessor data port address
    localparam logic [23:0] CBPX_COPROC_PORT = 24'h00_00FA;

    // Bus status encodings, active low; all ones is passive
    localparam logic [1:0] CBPX_STAT_IDLE = 2'h3;
    localparam logic [1:0] CBPX_STAT_READ = 2'h2;
    localparam logic [1:0] CBPX_STAT_WRITE = 2'h1;

    // Cycle type codes on the request port
    localparam logic [1:0] CBPX_REQ_MEM_READ = 2'h0;
    localparam logic [1:0] CBPX_REQ_MEM_WRITE = 2'h1;
    localparam logic [1:0] CBPX_REQ_IO_READ = 2'h2;
    localparam logic [1:0] CBPX_REQ_IO_WRITE = 2'h3;

    // Synchroniser depth for asynchronous inputs
    localparam int CBPX_SYNC_STAGES = 2;

    // Returns one when the cycle code is a write
    function automatic logic cbpx_is_write(input logic [1:0] kind);
        return kind[0];
    endfunction

endpackage

// ### verilog/cbpx_core.sv
`timescale 1ns/1ps
module cbpx_core
    import cbpx_pkg::*;
#(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // Asynchronous control inputs
    input wire logic maskable_irq_in_i,
    input wire logic nmi_i,
    input wire logic hold_req_i,
    input wire logic coproc_request_i,
    input wire logic coproc_error_i,
    input wire logic coproc_busy_i,
    // Ready from the clock and ready generator
    input wire logic ready_i,
    // Internal cycle request from the execution unit
    input wire logic cyc_req_i,
    input wire logic [1:0] cyc_kind_i,
    input wire logic [ADDR_W-1:0] cyc_addr_i,
    input wire logic [DATA_W-1:0] cyc_wdata_i,
    input wire logic cyc_lock_i,
    // Coprocessor operand address and direction
    input wire logic [ADDR_W-1:0] coproc_addr_i,
    input wire logic coproc_to_mem_i,
    // Read data from the bus
    input wire logic [DATA_W-1:0] data_i,
    // Cycle status to the execution unit
    output logic cyc_done_o,
    output logic [DATA_W-1:0] cyc_rdata_o,
    // Phase indicator
    output logic phase_o,
    // Address bus
    output logic [ADDR_W-1:0] addr_o,
    output logic addr_oe_o,
    // Bus status pins, active low
    output logic [1:0] status_o,
    output logic status_oe_o,
    output logic mio_o,
    // Byte enable and lock, active low
    output logic high_byte_enable_n_o,
    output logic lock_n_o,
    output logic ctl_oe_o,
    // Data bus
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_o,
    // Hold and coprocessor handshake
    output logic bus_hold_grant_o,
    output logic coproc_acknowledge_n_o,
    // Synchronised interrupt and coprocessor lines
    output logic irq_sync_o,
    output logic nmi_sync_o,
    output logic coproc_error_sync_o,
    output logic coproc_busy_sync_o
);

    // Reset release chain
    logic [1:0] rst_pipe;
    logic rst_n;

    // Asynchronous reset, synchronous release
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // Six asynchronous inputs through two-stage synchronisers
    logic [5:0] async_raw;
    logic [5:0] sync_a; // First stage, read only by sync_b
    logic [5:0] sync_b;
    assign async_raw = {coproc_busy_i, coproc_error_i, coproc_request_i,
                        hold_req_i, nmi_i, maskable_irq_in_i};

    // Synchroniser flops
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 6'h00;
            sync_b <= 6'h00;
        end else begin
            sync_a <= async_raw;
            sync_b <= sync_a;
        end
    end

    wire hold_s = sync_b[2];
    wire preq_s = sync_b[3];

    // Phase register: low means phase two comes next
    logic phase;
    logic next_phase;
    // Reset forces phase one; a late release simply shifts it a clock
    assign next_phase = ~phase;

    // Phase toggles every clock, so two clocks make a processor clock
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            phase <= CBPX_PHASE_ONE;
        end else begin
            phase <= next_phase;
        end
    end

    // Bus sequencer state
    cbpx_state_e state;
    cbpx_state_e next_state;
    logic [1:0] kind; // Cycle kind in flight
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic lock;
    logic last_was_write; // Previous cycle ended in a write command
    logic after_hold; // First cycle since hold ended
    logic [1:0] xfer_step; // Coprocessor transfer progress
    logic xfer_active;
    logic odd_byte; // Second byte of an odd operand pending

    // Cycles start only at a processor clock boundary
    wire boundary = (phase == CBPX_PHASE_TWO);
    wire cmd_end = (state == CBPX_COMMAND) && boundary && ready_i;
    wire odd_op = coproc_addr_i[0];
    // Coprocessor transfer wins over the execution unit
    wire start_xfer = preq_s && !xfer_active;
    wire want_cycle = cyc_req_i || start_xfer || xfer_active;

    // Next state decode
    always_comb begin
        next_state = state;
        unique case (state)
            CBPX_IDLE: begin
                if (hold_s && boundary) begin
                    next_state = CBPX_HOLD;
                end else if (want_cycle && boundary) begin
                    next_state = CBPX_STATUS;
                end
            end
            CBPX_STATUS: begin
                if (boundary) begin
                    next_state = CBPX_COMMAND;
                end
            end
            CBPX_COMMAND: begin
                // Ready low at a boundary holds the command state for another processor clock
                if (cmd_end) begin
                    next_state = CBPX_IDLE;
                end
            end
            CBPX_HOLD: begin
                if (!hold_s && boundary) begin
                    next_state = CBPX_IDLE;
                end
            end
        endcase
    end

    // Xfer step 0: read side; step 1: write side
    wire xfer_read_first = (xfer_step == 2'h0);
    wire [1:0] xfer_kind = xfer_read_first ?
        (coproc_to_mem_i ? CBPX_REQ_IO_READ : CBPX_REQ_MEM_READ) :
        (coproc_to_mem_i ? CBPX_REQ_MEM_WRITE : CBPX_REQ_IO_WRITE);
    wire xfer_is_mem = (xfer_kind == CBPX_REQ_MEM_READ) ||
                       (xfer_kind == CBPX_REQ_MEM_WRITE);
    wire [ADDR_W-1:0] xfer_addr = xfer_is_mem ?
        (coproc_addr_i + {{(ADDR_W-1){1'b0}}, odd_byte}) :
        CBPX_COPROC_PORT[ADDR_W-1:0];
    wire launch = (state == CBPX_IDLE) && (next_state == CBPX_STATUS);
    wire use_xfer = start_xfer || xfer_active;
    // Odd memory operand splits into two byte cycles
    wire split = xfer_is_mem && odd_op;
    wire xfer_last = !split || odd_byte;

    // Cycle capture and sequencing
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= CBPX_IDLE;
            kind <= CBPX_REQ_MEM_READ;
            addr <= '0;
            wdata <= '0;
            lock <= 1'b0;
            last_was_write <= 1'b0;
            after_hold <= 1'b0;
            xfer_step <= 2'h0;
            xfer_active <= 1'b0;
            odd_byte <= 1'b0;
        end else begin
            state <= next_state;
            if (launch) begin
                kind <= use_xfer ? xfer_kind : cyc_kind_i;
                addr <= use_xfer ? xfer_addr : cyc_addr_i;
                wdata <= use_xfer ? data_i : cyc_wdata_i;
                lock <= use_xfer ? 1'b0 : cyc_lock_i;
                xfer_active <= use_xfer;
            end
            if (cmd_end) begin
                last_was_write <= cbpx_is_write(kind);
                after_hold <= 1'b0;
                if (xfer_active) begin
                    // Advance through the byte halves, then the direction
                    if (!xfer_last) begin
                        odd_byte <= 1'b1;
                    end else begin
                        odd_byte <= 1'b0;
                        if (xfer_read_first) begin
                            xfer_step <= 2'h1;
                        end else begin
                            xfer_step <= 2'h0;
                            xfer_active <= 1'b0;
                        end
                    end
                end
            end
            if (state == CBPX_HOLD) begin
                after_hold <= 1'b1;
                last_was_write <= 1'b0;
            end
        end
    end

    // Pin drive decode
    wire in_hold = (state == CBPX_HOLD);
    wire in_status = (state == CBPX_STATUS);
    wire in_cmd = (state == CBPX_COMMAND);
    wire is_wr = cbpx_is_write(kind);
    // Write data held over into the next cycle's status state after a write
    wire drive_data = !in_hold &&
        ((in_cmd && is_wr) || (in_status && (is_wr || last_was_write)) ||
         (state == CBPX_IDLE && last_was_write)) &&
        !(after_hold && !is_wr);
    wire [1:0] next_status = in_hold ? CBPX_STAT_IDLE :
        (in_status ? (is_wr ? CBPX_STAT_WRITE : CBPX_STAT_READ) : CBPX_STAT_IDLE);
    wire byte_cycle = xfer_active && split;
    wire next_bhe_n = byte_cycle ? ~addr[0] : 1'b0;
    // Acknowledge only in the first operand cycle of the sequence
    wire first_op = xfer_active && xfer_read_first && !odd_byte;
    wire next_ack_n = !((in_status || in_cmd) && first_op);

    // Registered pin outputs
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            phase_o <= CBPX_PHASE_ONE;
            addr_o <= '0;
            addr_oe_o <= 1'b0;
            status_o <= CBPX_STAT_IDLE;
            status_oe_o <= 1'b0;
            mio_o <= 1'b0;
            high_byte_enable_n_o <= 1'b1;
            lock_n_o <= 1'b1;
            ctl_oe_o <= 1'b0;
            data_o <= '0;
            data_oe_o <= 1'b0;
            bus_hold_grant_o <= 1'b0;
            coproc_acknowledge_n_o <= 1'b1;
            cyc_done_o <= 1'b0;
            cyc_rdata_o <= '0;
        end else begin
            // Shows the phase the coming clock will run
            phase_o <= next_phase;
            addr_o <= addr;
            addr_oe_o <= !in_hold;
            // Status reads as all ones and floats during hold
            status_o <= next_status;
            status_oe_o <= !in_hold;
            mio_o <= (kind == CBPX_REQ_MEM_READ) || (kind == CBPX_REQ_MEM_WRITE);
            // Driven as soon as hold ends, meaningful from the status state
            ctl_oe_o <= !in_hold;
            high_byte_enable_n_o <= in_status || in_cmd ? next_bhe_n : 1'b1;
            lock_n_o <= in_status || in_cmd ? !lock : 1'b1;
            data_o <= wdata;
            data_oe_o <= drive_data;
            bus_hold_grant_o <= in_hold;
            // Requester must drop its line quickly or a second transfer starts
            coproc_acknowledge_n_o <= next_ack_n;
            cyc_done_o <= cmd_end && !xfer_active;
            if (cmd_end && !is_wr) begin
                cyc_rdata_o <= data_i;
            end
        end
    end

    // Synchronised copies for the execution unit
    assign irq_sync_o = sync_b[0];
    assign nmi_sync_o = sync_b[1];
    assign coproc_error_sync_o = sync_b[4];
    assign coproc_busy_sync_o = sync_b[5];

endmodule

// ### testbench/cbpx_checker.sv
`timescale 1ns/1ps
module cbpx_checker
    import cbpx_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // Watched inputs
    input wire logic nmi_i,
    // Watched outputs
    input wire logic phase_o,
    input wire logic addr_oe_o,
    input wire logic [1:0] status_o,
    input wire logic status_oe_o,
    input wire logic ctl_oe_o,
    input wire logic data_oe_o,
    input wire logic bus_hold_grant_o,
    input wire logic coproc_acknowledge_n_o,
    input wire logic nmi_sync_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    // Phase one then phase two
    sequence two_phase;
        !phase_o ##1 phase_o;
    endsequence
    // A bus cycle shows a non-idle status
    wire logic bus_active = status_oe_o && status_o != CBPX_STAT_IDLE;
    phase_alt_a: assert property (phase_o |=> !phase_o)
        else $error("phase two not followed by phase one");
    phase_rate_a: assert property ($rose(phase_o) |=> two_phase)
        else $error("processor clock not half the system clock");
    reset_phase_a: assert property ($rose(resetn_i) |-> !phase_o ##[1:6] phase_o)
        else $error("phase not aligned after reset");
    hold_float_a: assert property (bus_hold_grant_o |-> !addr_oe_o && !status_oe_o && !data_oe_o)
        else $error("bus driven during hold");
    ctl_status_a: assert property (bus_active |-> ctl_oe_o)
        else $error("byte enable and lock not driven in status");
    hold_read_a: assert property ($fell(bus_hold_grant_o) |-> !data_oe_o ##1 !data_oe_o)
        else $error("data driven when leaving hold");
    ack_read_a: assert property ($fell(coproc_acknowledge_n_o) |-> bus_active && status_o == CBPX_STAT_READ)
        else $error("acknowledge outside a read cycle");
    nmi_sync_a: assert property ($rose(nmi_i) |-> !nmi_sync_o ##1 !nmi_sync_o ##1 nmi_sync_o)
        else $error("interrupt sync latency wrong");
endmodule
bind cbpx_core cbpx_checker u_checker (.sys_clk_i, .resetn_i, .nmi_i, .phase_o, .addr_oe_o,
    .status_o, .status_oe_o, .ctl_oe_o, .data_oe_o, .bus_hold_grant_o,
    .coproc_acknowledge_n_o, .nmi_sync_o);

// ### testbench/cbpx_far_model.sv
`timescale 1ns/1ps
module cbpx_far_model
    import cbpx_pkg::*;
(
    // Clock
    input wire logic sys_clk_i,
    // Processor bus
    input wire logic [1:0] status_o,
    input wire logic status_oe_o,
    input wire logic addr_oe_o,
    input wire logic [23:0] addr_o,
    input wire logic coproc_acknowledge_n_o,
    // Bench controls
    input wire logic [1:0] wait_cnt_i,
    input wire logic xfer_go_i,
    // Answers
    output logic ready_o = 1'b1,
    output logic [15:0] data_o = 16'h0000,
    output logic coproc_request_o = 1'b0
);
    logic [2:0] hold_off = 3'h0; // Wait clocks left
    logic busy = 1'b0; // Cycle already seen
    logic [1:0] drop = 2'h0; // Clocks since acknowledge
    wire logic start = status_oe_o && status_o != CBPX_STAT_IDLE && !busy;
    // Ready stretches a command by two clocks per wait state
    always @(posedge sys_clk_i) begin
        busy <= status_oe_o && status_o != CBPX_STAT_IDLE;
        hold_off <= start ? {wait_cnt_i, 1'b0} : hold_off - 3'(hold_off != 0);
        ready_o <= start ? wait_cnt_i == 2'h0 : hold_off <= 3'h1;
        // Undriven bus toggles so stale data never looks valid
        data_o <= addr_oe_o ? addr_o[15:0] ^ 16'h5A5A : ~data_o;
        // Request dropped two clocks after acknowledge
        if (xfer_go_i) begin
            coproc_request_o <= 1'b1;
        end else if (drop == 2'h1) begin
            coproc_request_o <= 1'b0;
        end
        drop <= (!coproc_acknowledge_n_o && coproc_request_o) ? drop + 2'h1 : 2'h0;
    end
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import cbpx_pkg::*;
    logic sys_clk_i = 0, resetn_i = 0, maskable_irq_in_i = 0, nmi_i = 0, hold_req_i = 0;
    logic coproc_error_i = 0, coproc_busy_i = 0, ready_i, coproc_request_i, cyc_req_i = 0;
    logic [1:0] cyc_kind_i = 0, wait_cnt = 0, status_o;
    logic [23:0] cyc_addr_i = 0, coproc_addr_i = 0, addr_o;
    logic [15:0] cyc_wdata_i = 0, cyc_rdata_o, data_o, far_data;
    logic cyc_lock_i = 0, coproc_to_mem_i = 0, xfer_go = 0, cyc_done_o, phase_o, addr_oe_o;
    logic status_oe_o, mio_o, high_byte_enable_n_o, lock_n_o, ctl_oe_o, data_oe_o;
    logic bus_hold_grant_o, coproc_acknowledge_n_o, irq_sync_o, nmi_sync_o;
    logic coproc_error_sync_o, coproc_busy_sync_o, act = 0;
    logic op_doe[4], op_ack[4];
    logic [1:0] op_st[4];
    logic [23:0] op_addr[4];
    int error_cnt = 0, num_checks = 0, n_ops = 0;
    // Shared data wire: the processor wins while it drives
    wire logic [15:0] data_i = data_oe_o ? data_o : far_data;
    cbpx_core dut (.*);
    cbpx_far_model far (.sys_clk_i, .status_o, .status_oe_o, .addr_oe_o, .addr_o,
        .coproc_acknowledge_n_o, .wait_cnt_i(wait_cnt), .xfer_go_i(xfer_go),
        .ready_o(ready_i), .data_o(far_data), .coproc_request_o(coproc_request_i));
    always #12.5 sys_clk_i = ~sys_clk_i;
    // Record the first four bus operations as their status appears
    always @(posedge sys_clk_i) begin
        act <= status_oe_o && status_o != CBPX_STAT_IDLE;
        if (status_oe_o && status_o != CBPX_STAT_IDLE && !act && n_ops < 4) begin
            op_st[n_ops] <= status_o;
            op_doe[n_ops] <= data_oe_o;
            op_ack[n_ops] <= coproc_acknowledge_n_o;
            op_addr[n_ops] <= addr_o;
            n_ops <= n_ops + 1;
        end
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask
    task automatic tick(input int n = 1);
        repeat (n) @(posedge sys_clk_i);
        #2;
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Request held until done, then one idle clock
    task automatic run_cyc(input logic [1:0] k, input logic [23:0] a, output logic [15:0] rd);
        int n = 0;
        n_ops = 0;
        cyc_req_i = 1;
        cyc_kind_i = k;
        cyc_addr_i = a;
        cyc_wdata_i = ~a[15:0];
        while (cyc_done_o !== 1'b1 && n < 60) begin
            tick();
            n++;
        end
        chk(24'(n < 60), 24'h1, "cycle never finished");
        rd = cyc_rdata_o;
        cyc_req_i = 0;
        tick();
    endtask
    task automatic t_rw;
        logic [15:0] rd;
        for (int i = 0; i < 2; i++) begin
            wait_cnt = 2'(i * 2);
            run_cyc(i ? CBPX_REQ_IO_WRITE : CBPX_REQ_MEM_WRITE, 24'h00_0100, rd);
            run_cyc(i ? CBPX_REQ_IO_READ : CBPX_REQ_MEM_READ, 24'h00_0202, rd);
            chk(24'(op_doe[0]), 24'h1, "data not held after write");
            chk(24'(rd), 24'h00_5858, "read data wrong");
        end
    endtask
    task automatic t_phase;
        logic p;
        repeat (8) begin
            p = phase_o;
            tick();
            chk(24'(phase_o), 24'(!p), "phase did not alternate");
        end
    endtask
    task automatic t_hold;
        logic [15:0] rd;
        int n = 0;
        run_cyc(CBPX_REQ_MEM_WRITE, 24'h00_4000, rd);
        hold_req_i = 1;
        while (bus_hold_grant_o !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        chk(24'({addr_oe_o, status_oe_o, data_oe_o, bus_hold_grant_o}), 24'h1, "no float");
        hold_req_i = 0;
        tick(6);
        run_cyc(CBPX_REQ_MEM_READ, 24'h00_4002, rd);
        chk(24'(op_doe[0]), 24'h0, "data driven on read after hold");
    endtask
    // Coprocessor transfer: nm memory cycles plus one port cycle
    task automatic t_cop(input logic tm, input logic [23:0] a, input int nm);
        int n = 0;
        coproc_to_mem_i = tm;
        coproc_addr_i = a;
        n_ops = 0;
        xfer_go = 1;
        tick();
        xfer_go = 0;
        while (n_ops < nm + 1 && n < 100) begin
            tick();
            n++;
        end
        tick(30);
        chk(24'(n_ops), 24'(nm + 1), "operand cycle count");
        chk(24'({op_st[0], op_ack[0]}), 24'h4, "first cycle not an acked read");
        chk(op_addr[0], tm ? CBPX_COPROC_PORT : a, "first cycle address");
        if (nm == 2) chk(op_addr[tm ? 2 : 1], a + 24'h1, "second byte address");
    endtask
    task automatic t_sync;
        {maskable_irq_in_i, nmi_i, coproc_error_i, coproc_busy_i} = 4'hF;
        tick();
        chk(24'({irq_sync_o, nmi_sync_o, coproc_error_sync_o, coproc_busy_sync_o}), 24'h0, "early");
        tick(2);
        chk(24'({irq_sync_o, nmi_sync_o, coproc_error_sync_o, coproc_busy_sync_o}), 24'hF, "late");
    endtask
    initial begin
        tick(2);
        resetn_i = 1; // Released just after an edge, clear of setup
        tick(4);
        t_rw();
        t_phase(); // Phase trusted only after the first cycles
        t_hold();
        t_cop(0, 24'h00_0300, 1);
        t_cop(1, 24'h00_0304, 1);
        t_cop(0, 24'h00_0401, 2);
        t_cop(1, 24'h00_0501, 2);
        t_sync();
        print_verdict();
    end
    // Watchdog sized well above the whole sequence
    initial begin
        #(25 * 4000);
        error_cnt++;
        print_verdict();
    end
endmodule
